// >>> hdl/control_mode_select_alarm.sv
// Control mode selector and fault signalling of a servo drive
// Assumes terminals are active low and idle high; one clock domain
//
// How it works
// - Digits 4-6 pair preset speed with another
// - Limit inputs switch modes in preset pairings
// - Digits 7-B choose mode from switch input
// - 7: speed/position; 8: torque/position
// - 9: speed/torque; A: clamp/speed; B: inhibit
// - Fault output low normal, high in alarm
// - Alarm clears on a clear-input falling edge, not its level
// - Panel request also clears the alarm
// - Encoder faults clear only at power-up reset
// - Clear input terminal is remappable
// - Terminals sharing a function combine by OR
//
`timescale 1ns/1ps
`include "mode_alarm_consts.svh"
module control_mode_select_alarm
    import mode_alarm_pkg::*;
#(
    parameter int N_TERM = 8
) (
    input  wire logic              MCLK_IN,
    input  wire logic              RSTN_IN,
    input  wire logic [N_TERM-1:0] TERM_N_IN,
    input  wire logic              FAULT_EVENT_IN,
    input  wire logic              ENC_FAULT_IN,
    input  wire logic              PANEL_CLEAR_IN,
    input  wire logic [4:0]        ADDR_IN,
    input  wire logic [31:0]       WDATA_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    output logic      [31:0]       RDATA_OUT,
    output logic                   FAULT_OUT,
    output logic      [2:0]        MODE_OUT,
    output logic      [1:0]        PRESET_SEL_OUT,
    output logic                   IRQ_OUT
);

    // ==============================================================
    // Functions

    // True when any terminal mapped to a function is asserted
    function automatic logic func_hit(
        input logic [7:0]        mask,
        input logic [N_TERM-1:0] asserted
    );
        logic [7:0] wide;
        wide = '0;
        wide[N_TERM-1:0] = asserted;
        return |(mask & wide);
    endfunction

    // Gather all four input functions from terminal levels
    function automatic func_bits_t map_funcs(
        input logic [31:0]       alloc,
        input logic [N_TERM-1:0] asserted
    );
        func_bits_t f;
        f.fwd  = func_hit(alloc[`ALLOC_FWD_POS +: 8], asserted);
        f.rev  = func_hit(alloc[`ALLOC_REV_POS +: 8], asserted);
        f.prop = func_hit(alloc[`ALLOC_PRP_POS +: 8], asserted);
        f.clr  = func_hit(alloc[`ALLOC_CLR_POS +: 8], asserted);
        return f;
    endfunction

    // Mode from the method digit and the input functions
    function automatic ctrl_mode_t pick_mode(
        input logic [3:0] digit,
        input func_bits_t f
    );
        ctrl_mode_t m;
        logic       lim;
        // Either limit input requests the preset speed mode of digits 4-6
        lim = f.fwd | f.rev;
        case (digit)
            // Preset speed against analog speed
            `DIG_ISPD_ANA: begin
                m = lim ? MODE_SPD_INT : MODE_SPD_ANA;
            end
            // Preset speed against pulse-train speed
            `DIG_ISPD_PLS: begin
                m = lim ? MODE_SPD_INT : MODE_SPD_PULSE;
            end
            // Preset speed against analog torque
            `DIG_ISPD_TRQ: begin
                m = lim ? MODE_SPD_INT : MODE_TRQ;
            end
            // Switch asserted low picks the first mode
            `DIG_POS_SPD: begin
                m = f.prop ? MODE_SPD_ANA : MODE_POS;
            end
            `DIG_POS_TRQ: begin
                m = f.prop ? MODE_TRQ : MODE_POS;
            end
            `DIG_TRQ_SPD: begin
                m = f.prop ? MODE_SPD_ANA : MODE_TRQ;
            end
            `DIG_SPD_ZCL: begin
                m = f.prop ? MODE_ZCLAMP : MODE_SPD_ANA;
            end
            `DIG_POS_INH: begin
                m = f.prop ? MODE_POS_INHIBIT : MODE_POS;
            end
            // Digits outside the switching set stay in position
            default: begin
                m = MODE_POS;
            end
        endcase
        return m;
    endfunction

    // ==============================================================
    // Signals

    top_state_t        st_q;       // Registered state
    top_state_t        st_d;       // Next state
    reg_req_t          req;        // Bus request bundle
    logic [N_TERM-1:0] term_q;     // Synchronised levels
    logic [N_TERM-1:0] term_prev;  // Previous sample
    logic [N_TERM-1:0] asrt_now;   // Asserted terminals now
    logic [N_TERM-1:0] asrt_prev;  // Asserted terminals before
    func_bits_t        fn_now;     // Functions now
    func_bits_t        fn_prev;    // Functions one cycle before
    logic              clr_edge;   // Clear input falling edge
    logic              clear_req;  // Any clear request
    logic              fault;      // Latched fault
    logic              locked;     // Encoder lock
    logic              set_p;      // Fault entered
    logic              clr_p;      // Fault cleared
    logic [2:0]        events;     // Interrupt events
    logic [31:0]       status;     // Status word

    // ==============================================================
    // Bus bundle
    assign req = '{ADDR_IN, WDATA_IN, WR_IN, RD_IN};

    // ==============================================================
    // Input synchroniser with previous sample
    term_sync #(
        .W (N_TERM)
    ) u_sync (
        .clk_in   (MCLK_IN),
        .rstn_in  (RSTN_IN),
        .d_in     (TERM_N_IN),
        .q_out    (term_q),
        .prev_out (term_prev)
    );

    // ==============================================================
    // Input functions

    // Terminals are asserted when low
    assign asrt_now  = ~term_q;
    assign asrt_prev = ~term_prev;

    // Map terminals onto functions, now and one sample back
    assign fn_now  = map_funcs(st_q.alloc, asrt_now);
    assign fn_prev = map_funcs(st_q.alloc, asrt_prev);

    // One pulse per high-to-low move of the clear input
    assign clr_edge = fn_now.clr & ~fn_prev.clr;

    // Panel or operator request clears as well
    assign clear_req = clr_edge | PANEL_CLEAR_IN;

    // ==============================================================
    // Fault latch
    fault_latch u_latch (
        .clk_in         (MCLK_IN),
        .rstn_in        (RSTN_IN),
        .fault_event_in (FAULT_EVENT_IN),
        .enc_fault_in   (ENC_FAULT_IN),
        .clear_req_in   (clear_req),
        .fault_out      (fault),
        .locked_out     (locked),
        .set_pulse_out  (set_p),
        .clr_pulse_out  (clr_p)
    );

    // ==============================================================
    // Status word
    always_comb begin
        status = '0;
        status[`ST_MODE_POS +: 3]   = st_q.mode;
        status[`ST_PRESET_POS +: 2] = st_q.preset;
        status[`ST_FAULT_POS]       = fault;
        status[`ST_LOCK_POS]        = locked;
        status[`ST_TERM_POS +: N_TERM] = asrt_now;
    end

    // ==============================================================
    // Next state: mode, registers, interrupts, read data
    always_comb begin
        st_d = st_q;

        // Mode follows the digit and the inputs each cycle
        st_d.mode = pick_mode(st_q.digit, fn_now);
        // Preset index from the two limit inputs
        if (st_d.mode == MODE_SPD_INT) begin
            st_d.preset = {fn_now.rev, fn_now.fwd};
        end else begin
            st_d.preset = 2'h0;
        end

        // Writes to the software registers
        if (req.wr) begin
            case (req.addr)
                // Control-method digit
                `OFF_CTRL: begin
                    st_d.digit = req.wdata[3:0];
                end
                // Terminal allocation masks
                `OFF_ALLOC: begin
                    st_d.alloc = req.wdata;
                end
                // Interrupt mask
                `OFF_IRQ_MASK: begin
                    st_d.irq_mask = req.wdata[2:0];
                end
                // Read-only or unmapped: ignored
                default: begin
                    st_d.irq_mask = st_q.irq_mask;
                end
            endcase
        end

        // Event sources for the sticky flags
        events = '0;
        events[`IRQ_SET_BIT]  = set_p;
        events[`IRQ_CLR_BIT]  = clr_p;
        events[`IRQ_MODE_BIT] = (st_d.mode != st_q.mode);

        // Read clears the flags; a new event wins
        if (req.rd && req.addr == `OFF_IRQ_STAT) begin
            st_d.irq_stat = events;
        end else begin
            st_d.irq_stat = st_q.irq_stat | events;
        end

        // Interrupt level from unmasked flags
        st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

        // Read data stand one cycle, zero otherwise
        st_d.rdata = '0;
        if (req.rd) begin
            case (req.addr)
                // Control digit
                `OFF_CTRL: begin
                    st_d.rdata[3:0] = st_q.digit;
                end
                // Allocation masks
                `OFF_ALLOC: begin
                    st_d.rdata = st_q.alloc;
                end
                // Live status
                `OFF_STATUS: begin
                    st_d.rdata = status;
                end
                // Sticky flags before the clear
                `OFF_IRQ_STAT: begin
                    st_d.rdata[2:0] = st_q.irq_stat;
                end
                // Mask
                `OFF_IRQ_MASK: begin
                    st_d.rdata[2:0] = st_q.irq_mask;
                end
                // Unmapped reads return zero
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    // ==============================================================
    // State register
    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            st_q.digit    <= `RST_DIGIT;
            st_q.alloc    <= `RST_ALLOC;
            st_q.irq_stat <= 3'h0;
            st_q.irq_mask <= `RST_IRQ_MASK;
            st_q.rdata    <= 32'h0000_0000;
            st_q.mode     <= MODE_POS;
            st_q.preset   <= 2'h0;
            st_q.irq      <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==============================================================
    // Outputs, all from flip-flops
    assign RDATA_OUT      = st_q.rdata;
    assign FAULT_OUT      = fault;
    assign MODE_OUT       = st_q.mode;
    assign PRESET_SEL_OUT = st_q.preset;
    assign IRQ_OUT        = st_q.irq;

endmodule

// >>> hdl/mode_alarm_consts.svh
// Offsets, field positions and reset values of the mode/fault block
// Assumes inclusion by bare name from the top module
`ifndef MODE_ALARM_CONSTS_SVH
`define MODE_ALARM_CONSTS_SVH
// ==================================================================
// Register byte offsets
`define OFF_CTRL      5'h00
`define OFF_ALLOC     5'h04
`define OFF_STATUS    5'h08
`define OFF_IRQ_STAT  5'h0C
`define OFF_IRQ_MASK  5'h10
// ==================================================================
// Reset values
`define RST_DIGIT     4'h7
`define RST_ALLOC     32'h20028040
`define RST_IRQ_MASK  3'h0
// ==================================================================
// Field positions
`define ALLOC_FWD_POS 0
`define ALLOC_REV_POS 8
`define ALLOC_PRP_POS 16
`define ALLOC_CLR_POS 24
`define ST_MODE_POS   0
`define ST_PRESET_POS 4
`define ST_FAULT_POS  6
`define ST_LOCK_POS   7
`define ST_TERM_POS   8
`define IRQ_SET_BIT   0
`define IRQ_CLR_BIT   1
`define IRQ_MODE_BIT  2
// ==================================================================
// Control-method digits
`define DIG_ISPD_ANA  4'h4
`define DIG_ISPD_PLS  4'h5
`define DIG_ISPD_TRQ  4'h6
`define DIG_POS_SPD   4'h7
`define DIG_POS_TRQ   4'h8
`define DIG_TRQ_SPD   4'h9
`define DIG_SPD_ZCL   4'hA
`define DIG_POS_INH   4'hB
`endif

// >>> hdl/mode_alarm_pkg.sv
// Types shared by the mode selector and fault signalling block
// Assumes the constants header sits beside it
package mode_alarm_pkg;
    // ==============================================================
    // Active control mode, Gray along the usual path
    typedef enum logic [2:0] {
        MODE_POS         = 3'h0,
        MODE_SPD_ANA     = 3'h1,
        MODE_TRQ         = 3'h3,
        MODE_SPD_INT     = 3'h2,
        MODE_SPD_PULSE   = 3'h6,
        MODE_ZCLAMP      = 3'h7,
        MODE_POS_INHIBIT = 3'h5
    } ctrl_mode_t;
    // Fault latch states
    typedef enum logic [1:0] {
        FLT_NORMAL = 2'h0,
        FLT_ALARM  = 2'h1,
        FLT_LOCKED = 2'h3
    } fault_state_t;
    // One register bus request
    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
    // Logical input functions, true when asserted
    typedef struct packed {
        logic fwd;
        logic rev;
        logic prop;
        logic clr;
    } func_bits_t;
    // Whole state of the top module
    typedef struct packed {
        logic [3:0]  digit;
        logic [31:0] alloc;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [31:0] rdata;
        ctrl_mode_t  mode;
        logic [1:0]  preset;
        logic        irq;
    } top_state_t;
endpackage

// >>> hdl/term_sync.sv
// Two-stage synchroniser for the terminals, plus previous sample
// Assumes idle terminals sit high; reset loads that idle level
`timescale 1ns/1ps
module term_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out,
    output logic      [W-1:0] prev_out
);
    // Whole state of the synchroniser
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } sync_state_t;
    sync_state_t st_q;
    sync_state_t st_d;
    // ==============================================================
    // Next state: meta feeds only sync
    always_comb begin
        st_d.meta = d_in;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
    end
    // State register, idle high after reset
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end
    assign q_out    = st_q.sync;
    assign prev_out = st_q.prev;
endmodule

// >>> hdl/fault_latch.sv
// Fault latch: set by abnormal events, cleared by a clear request unless an encoder fault has locked it
// Assumes one-cycle clear requests already edge-detected upstream
`timescale 1ns/1ps
module fault_latch
    import mode_alarm_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic fault_event_in,
    input  wire logic enc_fault_in,
    input  wire logic clear_req_in,
    output logic      fault_out,
    output logic      locked_out,
    output logic      set_pulse_out,
    output logic      clr_pulse_out
);
    // Whole state of the latch
    typedef struct packed {
        fault_state_t state;
        logic         fault;
        logic         set_p;
        logic         clr_p;
    } latch_state_t;
    latch_state_t st_q;
    latch_state_t st_d;
    // ==============================================================
    // Next state; a new event beats a clear in the same cycle
    always_comb begin
        st_d       = st_q;
        st_d.set_p = 1'b0;
        st_d.clr_p = 1'b0;
        case (st_q.state)
            FLT_NORMAL: begin
                // Encoder faults lock until power cycling
                if (enc_fault_in) begin
                    st_d.state = FLT_LOCKED;
                    st_d.set_p = 1'b1;
                end else if (fault_event_in) begin
                    st_d.state = FLT_ALARM;
                    st_d.set_p = 1'b1;
                end
            end
            FLT_ALARM: begin
                // Clear on any cycle with a request and no new event
                if (enc_fault_in) begin
                    st_d.state = FLT_LOCKED;
                end else if (clear_req_in && !fault_event_in) begin
                    st_d.state = FLT_NORMAL;
                    st_d.clr_p = 1'b1;
                end
            end
            FLT_LOCKED: begin
                // Left only by reset
                st_d.state = FLT_LOCKED;
            end
            default: begin
                st_d.state = FLT_ALARM;
            end
        endcase
        // High in alarm, low when normal
        st_d.fault = (st_d.state != FLT_NORMAL);
    end
    // State register
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st_q <= '{FLT_NORMAL, 1'b0, 1'b0, 1'b0};
        end else begin
            st_q <= st_d;
        end
    end
    assign fault_out     = st_q.fault;
    assign locked_out    = (st_q.state == FLT_LOCKED);
    assign set_pulse_out = st_q.set_p;
    assign clr_pulse_out = st_q.clr_p;
endmodule

// >>> dv/plc_io_model.sv
// Model of the machine controller wiring at the drive's terminals
// Assumes one clock; terminals idle high, asserted low
`timescale 1ns/1ps
module plc_io_model (
    input  wire logic       clk_in,
    input  wire logic       fault_in,
    input  wire logic       cause_in,
    input  wire logic       sw_req_in,
    input  wire logic       fwd_req_in,
    input  wire logic       rev_req_in,
    input  wire logic       clr_req_in,
    input  wire logic       aux_req_in,
    output logic      [7:0] term_n_out,
    output logic            power_on_out
);
    // ==============================================================
    // Terminal drivers
    logic clr_low;                          // Clear line held low

    initial begin
        term_n_out = 8'hFF;
        clr_low = 1'b0;
    end

    // Clear only begins once the cause is gone, then holds
    always @(posedge clk_in) begin
        clr_low <= clr_req_in && (clr_low || !cause_in);
        term_n_out <= ~{rev_req_in, fwd_req_in,
                        clr_req_in && (clr_low || !cause_in),
                        3'h0, sw_req_in, aux_req_in};
    end

    // Main power contactor drops while the alarm stands
    assign power_on_out = !fault_in;
endmodule

// >>> dv/mode_alarm_assertions.sv
// Checker of the mode selector and fault block ports
// Assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module mode_alarm_checker #(
    parameter int N_TERM = 8
) (
    input wire logic              MCLK_IN,
    input wire logic              RSTN_IN,
    input wire logic [N_TERM-1:0] TERM_N_IN,
    input wire logic              FAULT_EVENT_IN,
    input wire logic              ENC_FAULT_IN,
    input wire logic              PANEL_CLEAR_IN,
    input wire logic              WR_IN,
    input wire logic              RD_IN,
    input wire logic [31:0]       RDATA_OUT,
    input wire logic              FAULT_OUT,
    input wire logic [2:0]        MODE_OUT,
    input wire logic [1:0]        PRESET_SEL_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // ==============================================================
    // Helper state
    logic [2:0] rst_cnt_q;                  // Edges since release
    logic       wr_seen_q;                  // Any write since reset
    logic       enc_seen_q;                 // Encoder fault seen

    // Track time since reset, writes and encoder faults
    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            rst_cnt_q  <= 3'h0;
            wr_seen_q  <= 1'b0;
            enc_seen_q <= 1'b0;
        end else begin
            rst_cnt_q  <= (rst_cnt_q == 3'h7) ? 3'h7 : rst_cnt_q + 3'h1;
            wr_seen_q  <= wr_seen_q || WR_IN;
            enc_seen_q <= enc_seen_q || ENC_FAULT_IN;
        end
    end

    // ==============================================================
    // Properties
    a_event_sets: assert property (
        FAULT_EVENT_IN |=> FAULT_OUT)
        else $error("fault output missed an event");
    a_fell_cause: assert property (
        $fell(FAULT_OUT) |-> $past(PANEL_CLEAR_IN)
        || (|($past(TERM_N_IN, 4) & ~$past(TERM_N_IN, 3)))
        || (|($past(TERM_N_IN, 5) & ~$past(TERM_N_IN, 4))))
        else $error("fault cleared without a falling clear");
    a_panel_clear: assert property (
        FAULT_OUT && PANEL_CLEAR_IN && !FAULT_EVENT_IN
        && !ENC_FAULT_IN && !enc_seen_q |=> !FAULT_OUT)
        else $error("panel request did not clear");
    a_enc_lock: assert property (
        enc_seen_q |-> FAULT_OUT)
        else $error("encoder fault released before reset");
    a_rdata_idle: assert property (
        !$past(RD_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data outside its cycle");
    a_preset_pair: assert property (
        (MODE_OUT == 3'h2) == (PRESET_SEL_OUT != 2'h0))
        else $error("preset select disagrees with mode");
    a_mode_cause: assert property (
        $changed(MODE_OUT) && rst_cnt_q == 3'h7 |-> $past(WR_IN, 2)
        || ($past(TERM_N_IN, 3) != $past(TERM_N_IN, 4)))
        else $error("mode changed without a cause");
    a_default_mode: assert property (
        !wr_seen_q && rst_cnt_q == 3'h7 |->
        MODE_OUT == ($past(TERM_N_IN[1], 3) ? 3'h0 : 3'h1))
        else $error("default pairing wrong");
endmodule

bind control_mode_select_alarm mode_alarm_checker #(
    .N_TERM(N_TERM)
) mode_alarm_checker_i (
    .MCLK_IN(MCLK_IN),
    .RSTN_IN(RSTN_IN),
    .TERM_N_IN(TERM_N_IN),
    .FAULT_EVENT_IN(FAULT_EVENT_IN),
    .ENC_FAULT_IN(ENC_FAULT_IN),
    .PANEL_CLEAR_IN(PANEL_CLEAR_IN),
    .WR_IN(WR_IN),
    .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT),
    .FAULT_OUT(FAULT_OUT),
    .MODE_OUT(MODE_OUT),
    .PRESET_SEL_OUT(PRESET_SEL_OUT)
);

// >>> dv/tb_top.sv
// Self-checking bench of the mode selector and fault block
// Assumes design, controller model and checker compiled first
`timescale 1ns/1ps
module tb_top;
    // ==============================================================
    // Signals
    logic        clk, rstn, fault_ev, enc_flt, panel_clr;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic        wr, rd, fault, irq, power;
    logic [2:0]  mode;
    logic [1:0]  preset;
    logic [7:0]  term_n;
    logic        sw, fwd, rev, clr, aux;  // Controller requests
    int          errors, total_checks;

    control_mode_select_alarm control_mode_select_alarm_i (
        .MCLK_IN(clk), .RSTN_IN(rstn), .TERM_N_IN(term_n),
        .FAULT_EVENT_IN(fault_ev), .ENC_FAULT_IN(enc_flt),
        .PANEL_CLEAR_IN(panel_clr), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .FAULT_OUT(fault),
        .MODE_OUT(mode), .PRESET_SEL_OUT(preset), .IRQ_OUT(irq));
    plc_io_model plc_io_model_i (
        .clk_in(clk), .fault_in(fault), .cause_in(fault_ev),
        .sw_req_in(sw), .fwd_req_in(fwd), .rev_req_in(rev),
        .clr_req_in(clr), .aux_req_in(aux), .term_n_out(term_n),
        .power_on_out(power));

    // ==============================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    // One-cycle pulse: 0 event, 1 panel clear, 2 encoder fault
    task automatic pulse(input int sel);
        @(posedge clk);
        {enc_flt, panel_clr, fault_ev} <= 3'h1 << sel;
        @(posedge clk);
        {enc_flt, panel_clr, fault_ev} <= 3'h0;
    endtask
    task automatic stop_test;
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Expected mode for a digit and asserted pair input
    function automatic logic [2:0] exp_mode(input int d, input int a);
        case (d)
            4: return a ? 3'h2 : 3'h1;
            5: return a ? 3'h2 : 3'h6;
            6: return a ? 3'h2 : 3'h3;
            7: return a ? 3'h1 : 3'h0;
            8: return a ? 3'h3 : 3'h0;
            9: return a ? 3'h1 : 3'h3;
            10: return a ? 3'h7 : 3'h1;
            11: return a ? 3'h5 : 3'h0;
            default: return 3'h0;
        endcase
    endfunction

    // ==============================================================
    // Clock and main sequence
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        {rstn, fault_ev, enc_flt, panel_clr, wr, rd} = 6'h0;
        {sw, fwd, rev, clr, aux} = 5'h0;
        addr = 5'h00;
        wdata = 32'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(5'h00); chk(q, 32'h7);
        rd_reg(5'h04); chk(q, 32'h20028040);
        rd_reg(5'h10); chk(q, 32'h0);
        rd_reg(5'h14); chk(q, 32'h0);
        sw <= 1'b1;
        tick(6); chk(32'(mode), 32'h1);
        sw <= 1'b0;
        tick(6); chk(32'(mode), 32'h0);
        for (int d = 3; d < 12; d++) begin
            for (int a = 0; a < 2; a++) begin
                wr_reg(5'h00, 32'(d));
                sw <= a[0];
                fwd <= a[0];
                tick(6);
                chk(32'(mode), 32'(exp_mode(d, a)));
                chk(32'(preset), (d > 3 && d < 7 && a == 1));
            end
        end
        rev <= 1'b1;
        fwd <= 1'b0;
        wr_reg(5'h00, 32'h4);
        tick(6); chk(32'(preset), 32'h2);
        rev <= 1'b0;
        wr_reg(5'h00, 32'h7);
        wr_reg(5'h10, 32'h7);
        tick(6);
        rd_reg(5'h0C);
        tick(2); chk(32'(irq), 32'h0);
        pulse(0);
        tick(2); chk(32'(fault), 32'h1);
        chk(32'(irq), 32'h1);
        rd_reg(5'h0C); chk(q, 32'h1);
        tick(2); chk(32'(irq), 32'h0);
        clr <= 1'b1;
        tick(8); chk(32'(fault), 32'h0);
        rd_reg(5'h0C); chk(q, 32'h2);
        pulse(0);
        tick(8); chk(32'(fault), 32'h1);
        clr <= 1'b0;
        tick(6); chk(32'(fault), 32'h1);
        pulse(1);
        tick(2); chk(32'(fault), 32'h0);
        wr_reg(5'h10, 32'h0);
        rd_reg(5'h0C);
        pulse(0);
        tick(3); chk(32'(irq), 32'h0);
        wr_reg(5'h08, 32'h0);
        rd_reg(5'h08); chk(32'(q[6]), 32'h1);
        wr_reg(5'h04, 32'h01018040);
        aux <= 1'b1;
        tick(8); chk(32'(mode), 32'h1);
        chk(32'(fault), 32'h0);
        rd_reg(5'h0C); chk(q, 32'h7);
        pulse(2);
        tick(2); chk(32'(fault), 32'h1);
        pulse(1);
        aux <= 1'b0;
        tick(3);
        aux <= 1'b1;
        tick(8); chk(32'(fault), 32'h1);
        rd_reg(5'h08); chk(32'(q[7]), 32'h1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        tick(2); chk(32'(fault), 32'h0);
        tick(10);
        stop_test();
    end
endmodule
